// >>> pkg/crf_regs.vh
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// Register select codes on the read and write ports
`define CRF_SEL_R0     4'h0
`define CRF_SEL_R1     4'h1
`define CRF_SEL_R2     4'h2
`define CRF_SEL_R3     4'h3
`define CRF_SEL_A0     4'h4
`define CRF_SEL_A1     4'h5
`define CRF_SEL_FB     4'h6
`define CRF_SEL_SB     4'h7
`define CRF_SEL_VECTOR_TABLE_BASE   4'h8
`define CRF_SEL_USP    4'h9
`define CRF_SEL_ISP    4'ha
`define CRF_SEL_SP     4'hb
`define CRF_SEL_FLG    4'hc
`define CRF_SEL_PC     4'hd

// Access sizes
`define CRF_SIZE_BYTE  2'h0
`define CRF_SIZE_WORD  2'h1
`define CRF_SIZE_LONG  2'h2

// Flag register bit positions
`define CRF_FLG_C      0
`define CRF_FLG_D      1
`define CRF_FLG_Z      2
`define CRF_FLG_S      3
`define CRF_FLG_B      4
`define CRF_FLG_O      5
`define CRF_FLG_U      7

// Widths
`define CRF_WORD_W     16
`define CRF_ADDR_W     20
`define CRF_FLG_W      11
`define CRF_BANK_REGS  7

// Reset values
`define CRF_RST_WORD   16'h0000
`define CRF_RST_ADDR   20'h00000
`define CRF_RST_FLG    11'h000

`endif

// >>> hdl/crf_bank.v
`timescale 1ns/10ps
`default_nettype none

module crf_bank #(
   parameter W = 16,
   parameter N = 7
) (
   input  wire           i_clk,
   input  wire           i_rst,
   input  wire           i_we,
   input  wire [2:0]     i_idx,
   input  wire [1:0]     i_be,
   input  wire [W-1:0]   i_data,
   input  wire           i_we2,
   input  wire [2:0]     i_idx2,
   input  wire [W-1:0]   i_data2,
   output wire [N*W-1:0] o_regs
);

   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_ent
         localparam [2:0] IDX = g;
         reg [W-1:0] r;
         always @(posedge i_clk) begin
            if (i_rst) begin
               r <= {W{1'b0}};
            end else if (i_we2 && i_idx2 == IDX) begin
               r <= i_data2;
            end else if (i_we && i_idx == IDX) begin
               // Byte lanes let the low data registers split in halves
               if (i_be[0]) begin
                  r[7:0] <= i_data[7:0];
               end
               if (i_be[1]) begin
                  r[W-1:8] <= i_data[W-1:8];
               end
            end
         end
         assign o_regs[g*W +: W] = r;
      end
   endgenerate

endmodule // crf_bank

`default_nettype wire

// >>> hdl/crf_core.v
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"

module crf_core #(
   parameter PC_STEP_W = 4
) (
   input  wire                   i_clk,
   input  wire                   i_rst,
   input  wire                   i_wr_en,
   input  wire [3:0]             i_wr_sel,
   input  wire [1:0]             i_wr_size,
   input  wire                   i_wr_hi,
   input  wire [31:0]            i_wr_data,
   input  wire [3:0]             i_rd_sel,
   input  wire [1:0]             i_rd_size,
   input  wire                   i_rd_hi,
   input  wire                   i_alu_done,
   input  wire [1:0]             i_alu_size,
   input  wire [31:0]            i_alu_result,
   input  wire                   i_alu_carry,
   input  wire                   i_alu_overflow,
   input  wire [3:0]             i_alu_upd,
   input  wire                   i_pc_adv,
   input  wire [PC_STEP_W-1:0]   i_pc_step,
   output reg  [31:0]            o_rd_data,
   output reg  [10:0]            o_flags,
   output reg  [19:0]            o_pc,
   output reg  [19:0]            o_vector_table_base,
   output reg  [15:0]            o_sb,
   output reg  [15:0]            o_usp,
   output reg  [15:0]            o_isp,
   output reg  [15:0]            o_sp,
   output reg  [15:0]            o_fb,
   output reg                    o_bank
);

   localparam BW = `CRF_WORD_W * `CRF_BANK_REGS;

   wire [BW-1:0] bank_regs [0:1];
   wire [BW-1:0] cur;
   wire          is_long;
   wire          is_byte;
   wire          bank_wr;
   wire          pair_ok;
   wire [2:0]    wr_idx;
   wire [2:0]    wr_idx2;
   wire [1:0]    wr_be;
   wire [15:0]   wr_word;
   wire          sp_user;

   reg  [10:0]   next_flg;
   reg  [19:0]   next_pc;
   reg  [19:0]   next_vector_table_base;
   reg  [15:0]   next_sb;
   reg  [15:0]   next_usp;
   reg  [15:0]   next_isp;
   reg  [31:0]   next_rd;
   reg  [31:0]   rd_full;
   reg  [31:0]   res_m;
   reg           res_sign;
   reg  [2:0]    rd_idx;
   reg  [2:0]    rd_idx2;

   assign is_long = (i_wr_size == `CRF_SIZE_LONG);
   assign is_byte = (i_wr_size == `CRF_SIZE_BYTE);
   assign bank_wr = i_wr_en && (i_wr_sel <= `CRF_SEL_FB);
   assign pair_ok = (i_wr_sel == `CRF_SEL_R0) ||
                    (i_wr_sel == `CRF_SEL_R1) ||
                    (i_wr_sel == `CRF_SEL_A0);
   assign wr_idx  = i_wr_sel[2:0];
   // Pair partner: third with first, fourth with second, a1 over a0
   assign wr_idx2 = (i_wr_sel == `CRF_SEL_A0) ? 3'h5
                                              : i_wr_sel[2:0] + 3'h2;
   assign wr_be   = is_byte ? (i_wr_hi ? 2'h2 : 2'h1) : 2'h3;
   assign wr_word = is_byte ? {i_wr_data[7:0], i_wr_data[7:0]}
                            : i_wr_data[15:0];
   // U clear means the user stack pointer is the active one
   assign sp_user = ~o_flags[`CRF_FLG_U];
   assign cur     = bank_regs[o_flags[`CRF_FLG_B]];

   genvar b;
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_bank
         localparam BSEL = b;
         wire sel_me;
         // Only the bank named by the bank-select flag takes writes
         assign sel_me = (o_flags[`CRF_FLG_B] == BSEL[0]);
         crf_bank #(
            .W (`CRF_WORD_W),
            .N (`CRF_BANK_REGS)
         ) u_bank (
            .i_clk   (i_clk),
            .i_rst   (i_rst),
            .i_we    (bank_wr && sel_me),
            .i_idx   (wr_idx),
            .i_be    (wr_be),
            .i_data  (wr_word),
            .i_we2   (bank_wr && sel_me && is_long && pair_ok),
            .i_idx2  (wr_idx2),
            .i_data2 (i_wr_data[31:16]),
            .o_regs  (bank_regs[b])
         );
      end
   endgenerate

   // Result masked to operand width for zero and sign detection
   always @* begin
      case (i_alu_size)
         `CRF_SIZE_BYTE: begin
            res_m    = {24'h000000, i_alu_result[7:0]};
            res_sign = i_alu_result[7];
         end
         `CRF_SIZE_WORD: begin
            res_m    = {16'h0000, i_alu_result[15:0]};
            res_sign = i_alu_result[15];
         end
         default: begin
            res_m    = i_alu_result;
            res_sign = i_alu_result[31];
         end
      endcase
   end

   always @* begin
      next_flg  = o_flags;
      next_pc   = o_pc;
      next_vector_table_base = o_vector_table_base;
      next_sb   = o_sb;
      next_usp  = o_usp;
      next_isp  = o_isp;
      // Each flag moves only when the finishing operation defines it
      if (i_alu_done) begin
         if (i_alu_upd[0]) begin
            next_flg[`CRF_FLG_C] = i_alu_carry;
         end
         if (i_alu_upd[1]) begin
            next_flg[`CRF_FLG_Z] = (res_m == 32'h00000000);
         end
         if (i_alu_upd[2]) begin
            next_flg[`CRF_FLG_S] = res_sign;
         end
         if (i_alu_upd[3]) begin
            next_flg[`CRF_FLG_O] = i_alu_overflow;
         end
      end
      if (i_pc_adv) begin
         next_pc = o_pc + {{(20-PC_STEP_W){1'b0}}, i_pc_step};
      end
      // A direct register write wins over flag and counter updates
      if (i_wr_en) begin
         case (i_wr_sel)
            `CRF_SEL_SB: begin
               next_sb = wr_word;
            end
            `CRF_SEL_VECTOR_TABLE_BASE: begin
               next_vector_table_base = is_long ? i_wr_data[19:0]
                                   : {o_vector_table_base[19:16], wr_word};
            end
            `CRF_SEL_USP: begin
               next_usp = wr_word;
            end
            `CRF_SEL_ISP: begin
               next_isp = wr_word;
            end
            `CRF_SEL_SP: begin
               if (sp_user) begin
                  next_usp = wr_word;
               end else begin
                  next_isp = wr_word;
               end
            end
            `CRF_SEL_FLG: begin
               next_flg = i_wr_data[10:0];
            end
            `CRF_SEL_PC: begin
               next_pc = is_long ? i_wr_data[19:0]
                                 : {o_pc[19:16], wr_word};
            end
            default: begin
               next_flg = next_flg;
            end
         endcase
      end
   end

   // Read mux; long reads of pairable registers return the pair
   always @* begin
      rd_idx  = i_rd_sel[2:0];
      rd_idx2 = (i_rd_sel == `CRF_SEL_A0) ? 3'h5 : i_rd_sel[2:0] + 3'h2;
      rd_full = 32'h00000000;
      case (i_rd_sel)
         `CRF_SEL_R0, `CRF_SEL_R1, `CRF_SEL_A0: begin
            rd_full = {cur[rd_idx2*16 +: 16], cur[rd_idx*16 +: 16]};
         end
         `CRF_SEL_R2, `CRF_SEL_R3, `CRF_SEL_A1, `CRF_SEL_FB: begin
            rd_full = {16'h0000, cur[rd_idx*16 +: 16]};
         end
         `CRF_SEL_SB:   rd_full = {16'h0000, o_sb};
         `CRF_SEL_VECTOR_TABLE_BASE: rd_full = {12'h000, o_vector_table_base};
         `CRF_SEL_USP:  rd_full = {16'h0000, o_usp};
         `CRF_SEL_ISP:  rd_full = {16'h0000, o_isp};
         `CRF_SEL_SP:   rd_full = {16'h0000, sp_user ? o_usp : o_isp};
         `CRF_SEL_FLG:  rd_full = {21'h00000, o_flags};
         `CRF_SEL_PC:   rd_full = {12'h000, o_pc};
         default:       rd_full = 32'h00000000;
      endcase
      case (i_rd_size)
         `CRF_SIZE_BYTE: begin
            next_rd = {24'h000000,
                       i_rd_hi ? rd_full[15:8] : rd_full[7:0]};
         end
         `CRF_SIZE_WORD: begin
            next_rd = (i_rd_sel == `CRF_SEL_VECTOR_TABLE_BASE || i_rd_sel == `CRF_SEL_PC)
                      ? rd_full : {16'h0000, rd_full[15:0]};
         end
         default: begin
            next_rd = rd_full;
         end
      endcase
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         o_flags   <= `CRF_RST_FLG;
         o_pc      <= `CRF_RST_ADDR;
         o_vector_table_base    <= `CRF_RST_ADDR;
         o_sb      <= `CRF_RST_WORD;
         o_usp     <= `CRF_RST_WORD;
         o_isp     <= `CRF_RST_WORD;
         o_sp      <= `CRF_RST_WORD;
         o_fb      <= `CRF_RST_WORD;
         o_bank    <= 1'b0;
         o_rd_data <= 32'h00000000;
      end else begin
         o_flags   <= next_flg;
         o_pc      <= next_pc;
         o_vector_table_base    <= next_vector_table_base;
         o_sb      <= next_sb;
         o_usp     <= next_usp;
         o_isp     <= next_isp;
         o_sp      <= next_flg[`CRF_FLG_U] ? next_isp : next_usp;
         o_bank    <= next_flg[`CRF_FLG_B];
         o_rd_data <= next_rd;
         // Frame base of the bank that will be current next cycle
         if (bank_wr && wr_idx == 3'h6 &&
             next_flg[`CRF_FLG_B] == o_flags[`CRF_FLG_B]) begin
            // Byte writes keep the untouched lane, as the bank does
            o_fb <= {wr_be[1] ? wr_word[15:8] : cur[6*16+8 +: 8],
                     wr_be[0] ? wr_word[7:0] : cur[6*16 +: 8]};
         end else begin
            o_fb <= bank_regs[next_flg[`CRF_FLG_B]][6*16 +: 16];
         end
      end
   end

endmodule // crf_core

`default_nettype wire

// >>> tb/crf_alu_model.sv
`timescale 1ns/10ps
`default_nettype none
module crf_alu_model (
   input  wire logic        i_clk,
   output var  logic        o_done,
   output var  logic [1:0]  o_size,
   output var  logic [31:0] o_result,
   output var  logic        o_carry,
   output var  logic        o_ovf,
   output var  logic [3:0]  o_upd
);
   initial begin
      o_done = 0; o_size = 0; o_result = 0;
      o_carry = 0; o_ovf = 0; o_upd = 0;
   end
   // Add at the given width; result is left unmasked on purpose
   task run(input [31:0] a, input [31:0] b, input [1:0] sz, input [3:0] u);
      logic [32:0] m;
      logic [32:0] s;
      int          w;
      w = (sz == 2'h0) ? 8 : (sz == 2'h1) ? 16 : 32;
      m = (33'h1 << w) - 33'h1;
      s = ({1'b0, a} & m) + ({1'b0, b} & m);
      @(negedge i_clk);
      o_done <= 1; o_size <= sz; o_upd <= u; o_result <= s[31:0];
      o_carry <= s[w];
      o_ovf <= (a[w-1] == b[w-1]) && (s[w-1] != a[w-1]);
      @(negedge i_clk);
      o_done <= 0;
      // Lines no longer valid: show something other than the last value
      o_result <= ~o_result; o_carry <= ~o_carry; o_ovf <= ~o_ovf;
   endtask
endmodule // crf_alu_model
`default_nettype wire

// >>> tb/crf_checker.sv
`timescale 1ns/10ps
`default_nettype none
module crf_checker #(parameter PC_STEP_W = 4) (
   input wire logic                 i_clk, i_rst, i_wr_en,
   input wire logic [3:0]           i_wr_sel, i_rd_sel, i_alu_upd,
   input wire logic [1:0]           i_wr_size, i_rd_size, i_alu_size,
   input wire logic [31:0]          i_wr_data, i_alu_result, o_rd_data,
   input wire logic                 i_alu_done, i_alu_carry, i_alu_overflow,
   input wire logic                 i_pc_adv, o_bank,
   input wire logic [PC_STEP_W-1:0] i_pc_step,
   input wire logic [10:0]          o_flags,
   input wire logic [19:0]          o_pc, o_vector_table_base,
   input wire logic [15:0]          o_sb, o_usp, o_isp, o_sp
);
   wire logic wr_flg = i_wr_en && i_wr_sel == 4'hc;
   wire logic z_exp = (i_alu_size == 2'h0) ? i_alu_result[7:0] == 8'h00 :
      (i_alu_size == 2'h1) ? i_alu_result[15:0] == 16'h0000 :
      i_alu_result == 32'h00000000;
   wire logic s_exp = (i_alu_size == 2'h0) ? i_alu_result[7] :
      (i_alu_size == 2'h1) ? i_alu_result[15] : i_alu_result[31];
   wire logic alu_ok = i_alu_done && !wr_flg;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   a_zero_flag: assert property (alu_ok && i_alu_upd[1] |=>
      o_flags[2] == $past(z_exp)) else $error("zero flag wrong");
   a_sign_flag: assert property (alu_ok && i_alu_upd[2] |=>
      o_flags[3] == $past(s_exp)) else $error("sign flag wrong");
   a_carry_flag: assert property (alu_ok && i_alu_upd[0] |=>
      o_flags[0] == $past(i_alu_carry)) else $error("carry flag wrong");
   a_ovf_flag: assert property (alu_ok && i_alu_upd[3] |=>
      o_flags[5] == $past(i_alu_overflow)) else $error("overflow wrong");
   a_flags_hold: assert property (!i_alu_done && !wr_flg |=>
      $stable(o_flags)) else $error("flags moved without cause");
   a_sp_select: assert property (
      o_sp == (o_flags[7] ? o_isp : o_usp))
      else $error("active stack pointer wrong");
   a_bank_copy: assert property (o_bank == o_flags[4])
      else $error("bank output differs from flag");
   a_pc_advance: assert property (i_pc_adv
      && !(i_wr_en && i_wr_sel == 4'hd)
      |=> o_pc - $past(o_pc) == $past(i_pc_step)) else $error("pc step wrong");
   a_sb_write: assert property (i_wr_en && i_wr_sel == 4'h7
      && i_wr_size == 2'h1 |=> o_sb == $past(i_wr_data[15:0]))
      else $error("static base write lost");
   a_vector_table_base_read: assert property (i_rd_sel == 4'h8
      && i_rd_size == 2'h1 && !i_wr_en
      |=> o_rd_data == {12'h000, $past(o_vector_table_base)})
      else $error("vector base read wrong");
   c_full_upd: cover property (i_alu_done && i_alu_upd == 4'hf);
   c_pc_adv: cover property (i_pc_adv);
   c_bank_back: cover property (o_bank ##1 !o_bank);
endmodule // crf_checker
`default_nettype wire

// >>> tb/tb_crf_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"
module tb_crf_core;
   typedef struct packed {
      logic [31:0] a; logic [31:0] b; logic [1:0] sz; logic [3:0] f;
   } crf_row_t;
   logic i_clk = 0, i_rst = 1, i_wr_en = 0, i_wr_hi = 0;
   logic i_rd_hi = 0, i_pc_adv = 0, i_alu_done, i_alu_carry, i_alu_overflow;
   logic [3:0] i_wr_sel = 0, i_rd_sel = 0, i_pc_step = 0, i_alu_upd;
   logic [1:0] i_wr_size = 0, i_rd_size = 0, i_alu_size;
   logic [31:0] i_wr_data = 0, i_alu_result, o_rd_data;
   logic [10:0] o_flags;
   logic [19:0] o_pc, o_vector_table_base;
   logic [15:0] o_sb, o_usp, o_isp, o_sp, o_fb;
   logic o_bank;
   wire [3:0] flg_oszc = {o_flags[5], o_flags[3:2], o_flags[0]};
   int fails = 0, n_compared = 0;
   crf_row_t rows [0:3];
   crf_core #(.PC_STEP_W(4)) crf_core_i (.*);
   crf_alu_model crf_alu_model_i (.i_clk, .o_done(i_alu_done),
      .o_size(i_alu_size), .o_result(i_alu_result), .o_carry(i_alu_carry),
      .o_ovf(i_alu_overflow), .o_upd(i_alu_upd));
   initial forever #2 i_clk = ~i_clk;
   task results;
      if (fails == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input [3:0] s, input [1:0] z, input h, input [31:0] d);
      @(negedge i_clk);
      i_wr_en = 1; i_wr_sel = s; i_wr_size = z; i_wr_hi = h; i_wr_data = d;
      @(negedge i_clk);
      i_wr_en = 0;
   endtask
   task rd(input [3:0] s, input [1:0] z, input h, input [31:0] e);
      @(negedge i_clk);
      i_rd_sel = s; i_rd_size = z; i_rd_hi = h;
      @(negedge i_clk);
      chk(o_rd_data, e);
   endtask
   initial begin
      #40000;
      fails++;
      results;
   end
   initial begin
      // Expected flags as {O, S, Z, C}
      rows[0] = '{32'h000000ff, 32'h00000001, 2'h0, 4'b0011};
      rows[1] = '{32'h1234567f, 32'h00000001, 2'h0, 4'b1100};
      rows[2] = '{32'h00008000, 32'h00008000, 2'h1, 4'b1011};
      rows[3] = '{32'hffffffff, 32'h00000002, 2'h3, 4'b0001};
      repeat (3) @(negedge i_clk);
      i_rst = 0;
      chk(o_flags, 0);
      chk(o_pc, 0);
      foreach (rows[k]) begin
         crf_alu_model_i.run(rows[k].a, rows[k].b, rows[k].sz, 4'hf);
         chk(flg_oszc, rows[k].f);
      end
      crf_alu_model_i.run(0, 0, 2'h1, 4'h2);
      chk(flg_oszc, 4'b0011);
      wr(`CRF_SEL_R0, `CRF_SIZE_LONG, 0, 32'hcafe1234);
      rd(`CRF_SEL_R0, `CRF_SIZE_LONG, 0, 32'hcafe1234);
      rd(`CRF_SEL_R2, `CRF_SIZE_WORD, 0, 32'h0000cafe);
      wr(`CRF_SEL_R0, `CRF_SIZE_BYTE, 1, 32'h00000055);
      rd(`CRF_SEL_R0, `CRF_SIZE_WORD, 0, 32'h00005534);
      rd(`CRF_SEL_R0, `CRF_SIZE_BYTE, 1, 32'h00000055);
      wr(`CRF_SEL_R1, `CRF_SIZE_LONG, 0, 32'h89abcdef);
      rd(`CRF_SEL_R3, `CRF_SIZE_WORD, 0, 32'h000089ab);
      wr(`CRF_SEL_A0, `CRF_SIZE_LONG, 0, 32'h11112222);
      rd(`CRF_SEL_A1, `CRF_SIZE_WORD, 0, 32'h00001111);
      wr(`CRF_SEL_VECTOR_TABLE_BASE, `CRF_SIZE_LONG, 0, 32'hfffabcde);
      rd(`CRF_SEL_VECTOR_TABLE_BASE, `CRF_SIZE_WORD, 0, 32'h000abcde);
      wr(`CRF_SEL_SB, `CRF_SIZE_WORD, 0, 32'h00005a5a);
      rd(`CRF_SEL_SB, `CRF_SIZE_WORD, 0, 32'h00005a5a);
      rd(4'he, `CRF_SIZE_WORD, 0, 32'h00000000);
      wr(`CRF_SEL_FB, `CRF_SIZE_WORD, 0, 32'h00000f0f);
      wr(`CRF_SEL_FLG, `CRF_SIZE_WORD, 0, 32'h00000010);
      chk(o_bank, 1);
      chk(o_fb, 0);
      rd(`CRF_SEL_R0, `CRF_SIZE_WORD, 0, 32'h00000000);
      wr(`CRF_SEL_FB, `CRF_SIZE_WORD, 0, 32'h0000b1b1);
      wr(`CRF_SEL_FLG, `CRF_SIZE_WORD, 0, 32'h00000000);
      chk(o_fb, 32'h00000f0f);
      rd(`CRF_SEL_R0, `CRF_SIZE_LONG, 0, 32'hcafe5534);
      wr(`CRF_SEL_USP, `CRF_SIZE_WORD, 0, 32'h00001000);
      wr(`CRF_SEL_ISP, `CRF_SIZE_WORD, 0, 32'h00002000);
      wr(`CRF_SEL_FLG, `CRF_SIZE_WORD, 0, 32'h00000080);
      chk(o_sp, 32'h00002000);
      wr(`CRF_SEL_SP, `CRF_SIZE_WORD, 0, 32'h00002222);
      chk(o_isp, 32'h00002222);
      wr(`CRF_SEL_FLG, `CRF_SIZE_WORD, 0, 32'h00000000);
      chk(o_sp, 32'h00001000);
      rd(`CRF_SEL_SP, `CRF_SIZE_WORD, 0, 32'h00001000);
      wr(`CRF_SEL_PC, `CRF_SIZE_LONG, 0, 32'h000ffffe);
      i_pc_adv = 1; i_pc_step = 4'h3;
      @(negedge i_clk);
      i_pc_adv = 0;
      chk(o_pc, 32'h00000001);
      i_rst = 1;
      @(negedge i_clk);
      i_rst = 0;
      chk(o_pc, 0);
      chk(o_usp, 0);
      results;
   end
endmodule // tb_crf_core
bind crf_core crf_checker #(.PC_STEP_W(PC_STEP_W)) crf_checker_i (.i_clk,
   .i_rst, .i_wr_en, .i_wr_sel, .i_rd_sel, .i_alu_upd, .i_wr_size,
   .i_rd_size, .i_alu_size, .i_wr_data, .i_alu_result, .o_rd_data,
   .i_alu_done, .i_alu_carry, .i_alu_overflow, .i_pc_adv, .o_bank,
   .i_pc_step, .o_flags, .o_pc, .o_vector_table_base, .o_sb, .o_usp, .o_isp, .o_sp);
`default_nettype wire
